/* File: inc/wdpor_params.svh */
// Offsets, field positions, reset values and counts of the watchdog block
`ifndef WDPOR_PARAMS_SVH
`define WDPOR_PARAMS_SVH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define WDP_CTRL_ADDR 8'hE1
`define WDP_PWR_ADDR 8'hE2

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define WDP_RUN_BIT 5
`define WDP_RESTART_BIT 4
`define WDP_IDLE_BIT 3
`define WDP_PS_MSB 2
`define WDP_PS_LSB 0
`define WDP_PLF_BIT 4

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define WDP_CTRL_RST 8'h00
`define WDP_APP_START 16'h0000

// ----------------------------------------------------------------------
// Widths and counts
// ----------------------------------------------------------------------
`define WDP_PRE_W 8
`define WDP_CNT_W 15
`define WDP_DLY_W 16
`define WDP_DIV_W 4
`define WDP_OSC_DIV 12
`define WDP_SHORT_DELAY 2048
`define WDP_LONG_DELAY 32768
`define WDP_WD_RST_CLKS 4

`endif

/* File: inc/wdpor_pkg.sv */
// Types shared by the watchdog and power-on reset modules
`include "wdpor_params.svh"

package wdpor_pkg;

  typedef enum logic [3:0] {
    ST_HOLD = 4'h1,
    ST_DELAY = 4'h2,
    ST_RUN = 4'h4,
    ST_WDRST = 4'h8
  } wdpor_state_t;

  typedef struct packed {
    wdpor_state_t state;
    logic run_enable;
    logic restart;
    logic idle_run;
    logic [2:0] prescale_sel;
    logic power_loss_flag;
    logic [`WDP_PRE_W-1:0] prescaler;
    logic [`WDP_CNT_W-1:0] counter;
    logic [`WDP_DLY_W-1:0] delay_cnt;
    logic [7:0] wd_rst_cnt;
    logic [7:0] rdata;
    logic sys_reset;
    logic wd_timeout;
    logic cpu_start;
    logic [15:0] restart_vector;
  } wdpor_regs_t;

  typedef struct packed {
    logic [`WDP_DIV_W-1:0] cnt;
  } wdpor_div_t;

endpackage : wdpor_pkg

/* File: inc/wdpor_tick_if.sv */
// Carrier between the watchdog core and its oscillator divider
`timescale 1ns/1ps

interface wdpor_tick_if;
  logic run;
  logic clear;
  logic tick;

  modport ctl (
    output run,
    output clear,
    input tick
  );

  modport div (
    input run,
    input clear,
    output tick
  );
endinterface : wdpor_tick_if

/* File: core/wdpor_div12.sv */
// Divider that turns oscillator clocks into watchdog count ticks
`timescale 1ns/1ps
`include "wdpor_params.svh"

module wdpor_div12
  import wdpor_pkg::*;
#(
  parameter int DIV = `WDP_OSC_DIV
) (
  input wire logic clk,
  input wire logic rst_n,
  wdpor_tick_if.div tif
);

  localparam logic [`WDP_DIV_W-1:0] LAST = `WDP_DIV_W'(DIV - 1);

  wdpor_div_t r;
  wdpor_div_t nx;

  // ----------------------------------------------------------------------
  // Count oscillator clocks
  // ----------------------------------------------------------------------
  always_comb begin
    nx = r;
    if (tif.clear) begin
      nx.cnt = '0;
    end else if (tif.run) begin
      if (r.cnt == LAST) begin
        nx.cnt = '0;
      end else begin
        nx.cnt = r.cnt + `WDP_DIV_W'(1);
      end
    end
  end

  // One tick per twelve counted clocks
  assign tif.tick = tif.run && !tif.clear && (r.cnt == LAST);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      r <= '0;
    end else begin
      r <= nx;
    end
  end

endmodule : wdpor_div12

/* File: core/wdpor_top.sv */
// Watchdog timer with power-on reset release and its register port
//
// The implementer's own choice: the plain strobed port.
`timescale 1ns/1ps
`include "wdpor_params.svh"

//
// Overview of operation
// - Low supply holds all logic in reset
// - Release reset after fixed clock delay
// - Power-on event sets power loss flag
// - Flag survives other resets; software clears it
// - Eight-bit prescaler feeds fifteen-bit counter
// - Writing run enable one starts counting
// - Writing run enable zero stops counting
// - Restart clears counters; bit self-clears
// - Counter overflow asserts internal system reset
// - Idle-run bit decides counting while idle
// - Prescale divisor is two to (select+1)
// - Count advances every twelve oscillator clocks
// - Watchdog reset restarts application at zero
//

module wdpor_top
  import wdpor_pkg::*;
#(
  parameter int SHORT_DELAY_CLKS = `WDP_SHORT_DELAY,
  parameter int LONG_DELAY_CLKS = `WDP_LONG_DELAY,
  parameter bit LONG_DELAY_VARIANT = 1'b0,
  parameter int WD_RESET_CLKS = `WDP_WD_RST_CLKS,
  parameter int WD_COUNT_W = `WDP_CNT_W
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic por_detect,
  input wire logic cpu_idle,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  output logic sys_reset,
  output logic wd_timeout,
  output logic cpu_start,
  output logic [15:0] restart_vector,
  output logic power_loss_flag
);

  // ----------------------------------------------------------------------
  // Constants
  // ----------------------------------------------------------------------
  localparam int DELAY_CLKS = LONG_DELAY_VARIANT ? LONG_DELAY_CLKS : SHORT_DELAY_CLKS;
  localparam logic [`WDP_DLY_W-1:0] DLY_LAST = `WDP_DLY_W'(DELAY_CLKS - 1);
  localparam logic [7:0] WDR_LAST = 8'(WD_RESET_CLKS - 1);
  // A narrower count only shortens the timeout; its upper bits then stay zero
  localparam int CNT_SPAN = (WD_COUNT_W < `WDP_CNT_W) ? WD_COUNT_W : `WDP_CNT_W;
  localparam logic [`WDP_CNT_W-1:0] CNT_MAX = `WDP_CNT_W'((32'h1 << CNT_SPAN) - 32'h1);
  localparam int PS_N = `WDP_PRE_W;

  // ----------------------------------------------------------------------
  // State and decode
  // ----------------------------------------------------------------------
  wdpor_regs_t r;
  wdpor_regs_t nx;

  logic in_run;
  logic ctrl_wr;
  logic pwr_wr;
  logic restart_wr;
  logic count_en;
  logic [PS_N-1:0] tap_hit;
  logic pre_tick;
  logic overflow;
  logic [7:0] ctrl_val;
  logic [7:0] pwr_val;

  wdpor_tick_if tif ();

  wdpor_div12 #(
    .DIV(`WDP_OSC_DIV)
  ) u_div (
    .clk(clk),
    .rst_n(rst_n),
    .tif(tif)
  );

  // Writes land only while the system runs; in reset the control fields stay zero
  assign in_run = (r.state == ST_RUN);
  assign ctrl_wr = reg_wr && in_run && (reg_addr == `WDP_CTRL_ADDR);
  assign pwr_wr = reg_wr && in_run && (reg_addr == `WDP_PWR_ADDR);
  assign restart_wr = ctrl_wr && reg_wdata[`WDP_RESTART_BIT];

  // Idle pauses the count unless idle-run is set
  assign count_en = r.run_enable && (!cpu_idle || r.idle_run);
  assign tif.run = in_run && count_en;
  assign tif.clear = !in_run || restart_wr;

  // ----------------------------------------------------------------------
  // Prescaler taps
  // ----------------------------------------------------------------------
  // Divide by 2^(i+1) ends where the low i+1 prescaler bits are all ones
  for (genvar gi = 0; gi < PS_N; gi++) begin : g_tap
    assign tap_hit[gi] = &r.prescaler[gi:0];
  end

  assign pre_tick = tif.tick && tap_hit[r.prescale_sel];
  assign overflow = pre_tick && (r.counter == CNT_MAX);

  // Unimplemented bits read as zero
  assign ctrl_val = {2'b00, r.run_enable, r.restart, r.idle_run, r.prescale_sel};
  assign pwr_val = {3'b000, r.power_loss_flag, 4'h0};

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb begin
    nx = r;
    nx.wd_timeout = 1'b0;
    nx.cpu_start = 1'b0;
    nx.restart = 1'b0;
    nx.rdata = 8'h00;

    // Read data stands only in the cycle after the strobe
    if (reg_rd) begin
      case (reg_addr)
        `WDP_CTRL_ADDR: begin
          nx.rdata = ctrl_val;
        end
        `WDP_PWR_ADDR: begin
          nx.rdata = pwr_val;
        end
        default: begin
          nx.rdata = 8'h00;
        end
      endcase
    end

    // Control register writes
    if (ctrl_wr) begin
      nx.run_enable = reg_wdata[`WDP_RUN_BIT];
      nx.idle_run = reg_wdata[`WDP_IDLE_BIT];
      nx.prescale_sel = reg_wdata[`WDP_PS_MSB:`WDP_PS_LSB];
      nx.restart = reg_wdata[`WDP_RESTART_BIT];
    end

    // Watchdog count chain
    if (tif.tick) begin
      nx.prescaler = r.prescaler + `WDP_PRE_W'(1);
    end
    if (pre_tick) begin
      nx.counter = r.counter + `WDP_CNT_W'(1);
    end
    if (restart_wr) begin
      nx.prescaler = '0;
      nx.counter = '0;
    end

    // Only software clears the flag, and only by writing zero
    if (pwr_wr && !reg_wdata[`WDP_PLF_BIT]) begin
      nx.power_loss_flag = 1'b0;
    end

    case (r.state)
      ST_HOLD: begin
        nx.delay_cnt = '0;
        if (!por_detect) begin
          nx.state = ST_DELAY;
        end
      end
      ST_DELAY: begin
        if (por_detect) begin
          nx.state = ST_HOLD;
        end else if (r.delay_cnt == DLY_LAST) begin
          nx.state = ST_RUN;
          nx.cpu_start = 1'b1;
          nx.restart_vector = `WDP_APP_START;
        end else begin
          nx.delay_cnt = r.delay_cnt + `WDP_DLY_W'(1);
        end
      end
      ST_RUN: begin
        if (por_detect) begin
          nx.state = ST_HOLD;
        end else if (overflow && !restart_wr) begin
          nx.state = ST_WDRST;
          nx.wd_timeout = 1'b1;
          nx.wd_rst_cnt = 8'h00;
        end
      end
      ST_WDRST: begin
        if (por_detect) begin
          nx.state = ST_HOLD;
        end else if (r.wd_rst_cnt == WDR_LAST) begin
          nx.state = ST_RUN;
          nx.cpu_start = 1'b1;
          nx.restart_vector = `WDP_APP_START;
        end else begin
          nx.wd_rst_cnt = r.wd_rst_cnt + 8'h01;
        end
      end
      default: begin
        nx.state = ST_HOLD;
      end
    endcase

    // Any internal reset returns every control field to zero
    if (nx.state != ST_RUN) begin
      nx.run_enable = 1'b0;
      nx.restart = 1'b0;
      nx.idle_run = 1'b0;
      nx.prescale_sel = 3'h0;
      nx.prescaler = '0;
      nx.counter = '0;
    end

    // Set wins over a same-cycle clear
    if (por_detect || (r.state == ST_HOLD)) begin
      nx.power_loss_flag = 1'b1;
    end

    nx.sys_reset = (nx.state != ST_RUN);
  end

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      r <= '0;
      r.state <= ST_HOLD;
      r.sys_reset <= 1'b1;
      r.restart_vector <= `WDP_APP_START;
    end else begin
      r <= nx;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign reg_rdata = r.rdata;
  assign sys_reset = r.sys_reset;
  assign wd_timeout = r.wd_timeout;
  assign cpu_start = r.cpu_start;
  assign restart_vector = r.restart_vector;
  assign power_loss_flag = r.power_loss_flag;

endmodule : wdpor_top

/* File: testbench/wdpor_asserts.sv */
// Port checker for the watchdog and power-on reset block
`timescale 1ns/1ps
module wdpor_asserts (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic por_detect,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic [7:0] reg_rdata,
  input wire logic sys_reset,
  input wire logic wd_timeout,
  input wire logic cpu_start,
  input wire logic [15:0] restart_vector,
  input wire logic power_loss_flag
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_por_off;
    por_detect ##1 !por_detect;
  endsequence
  sequence s_flag_clear;
    reg_wr && reg_addr == 8'hE2 && !reg_wdata[4];
  endsequence
  property p_por_hold; por_detect |=> sys_reset; endproperty
  a_por_hold: assert property (p_por_hold)
    else $error("reset not held while supply low");
  property p_por_release; s_por_off |-> sys_reset [*8]; endproperty
  a_por_release: assert property (p_por_release)
    else $error("reset released too early");
  property p_flag_por; por_detect |=> power_loss_flag; endproperty
  a_flag_por: assert property (p_flag_por)
    else $error("power flag not set");
  property p_flag_keep;
    power_loss_flag && !(reg_wr && reg_addr == 8'hE2 && !reg_wdata[4]) |=> power_loss_flag;
  endproperty
  a_flag_keep: assert property (p_flag_keep)
    else $error("power flag lost");
  property p_flag_clear; s_flag_clear ##0 (!sys_reset && !por_detect) |=> !power_loss_flag;
  endproperty
  a_flag_clear: assert property (p_flag_clear)
    else $error("power flag not cleared by software");
  property p_timeout; wd_timeout |-> sys_reset ##1 !wd_timeout; endproperty
  a_timeout: assert property (p_timeout)
    else $error("timeout without system reset");
  property p_start; $fell(sys_reset) |-> cpu_start; endproperty
  a_start: assert property (p_start)
    else $error("no start pulse at release");
  property p_vector; restart_vector == 16'h0000; endproperty
  a_vector: assert property (p_vector)
    else $error("start address not zero");
  property p_rdata_zero; !$past(reg_rd) |-> reg_rdata == 8'h00; endproperty
  a_rdata_zero: assert property (p_rdata_zero)
    else $error("read data outside read cycle");
  property p_ctrl_top; reg_rd && reg_addr == 8'hE1 |=> reg_rdata[7:6] == 2'b00; endproperty
  a_ctrl_top: assert property (p_ctrl_top)
    else $error("upper control bits not zero");
endmodule : wdpor_asserts

bind wdpor_top wdpor_asserts wdpor_asserts_i (.clk(clk), .rst_n(rst_n),
  .por_detect(por_detect), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rdata(reg_rdata), .sys_reset(sys_reset), .wd_timeout(wd_timeout),
  .cpu_start(cpu_start), .restart_vector(restart_vector), .power_loss_flag(power_loss_flag));

/* File: testbench/tb_top.sv */
// Self-checking testbench of the watchdog and power-on reset block
`timescale 1ns/1ps
`include "wdpor_params.svh"
module tb_top;
  logic clk, rst_n, por_detect, cpu_idle, reg_wr, reg_rd;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic sys_reset, wd_timeout, cpu_start, power_loss_flag;
  logic [15:0] restart_vector;
  int err_count = 0;
  int compares = 0;
  int n;
  int k;
  int wd_pulses = 0;
  localparam int CW = 3;

  // Short release delay and narrow count keep the run brief
  wdpor_top #(.SHORT_DELAY_CLKS(16), .LONG_DELAY_CLKS(64), .WD_COUNT_W(CW)) wdpor_top_i (
    .clk(clk),
    .rst_n(rst_n), .por_detect(por_detect), .cpu_idle(cpu_idle), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .sys_reset(sys_reset), .wd_timeout(wd_timeout), .cpu_start(cpu_start),
    .restart_vector(restart_vector), .power_loss_flag(power_loss_flag));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // Counts every timeout pulse, so one between checks is not missed
  always @(posedge clk) begin
    if (wd_timeout === 1'b1) begin
      wd_pulses <= wd_pulses + 1;
    end
  end

  // ----------------------------------------------------------------
  // Bus and compare tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // Extra edge so the strobe is never raised again in the same step
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
    @(posedge clk);
  endtask : wr

  task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    check(16'(reg_rdata), 16'(exp));
    @(posedge clk);
  endtask : rdchk

  task automatic wait_release(output int cnt);
    cnt = 0;
    while (sys_reset !== 1'b0 && cnt < 200) begin
      @(posedge clk);
      #1;
      cnt++;
    end
  endtask : wait_release

  task automatic wait_timeout(output int cnt);
    cnt = 0;
    while (wd_timeout !== 1'b1 && cnt < 3000) begin
      @(posedge clk);
      #1;
      cnt++;
    end
  endtask : wait_timeout

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_regs();
    rdchk(8'hE1, 8'h00);
    wr(8'hE1, 8'hFF);
    rdchk(8'hE1, 8'h2F);
    wr(8'hE1, 8'h00);
    rdchk(8'hE1, 8'h00);
    rdchk(8'h55, 8'h00);
  endtask : t_regs

  task automatic t_flag();
    rdchk(8'hE2, 8'h10);
    wr(8'hE2, 8'hFF);
    rdchk(8'hE2, 8'h10);
    wr(8'hE2, 8'h00);
    rdchk(8'hE2, 8'h00);
  endtask : t_flag

  task automatic t_por();
    wr(8'hE1, 8'h27);
    por_detect <= 1'b1;
    @(posedge clk);
    #1;
    check(16'(sys_reset), 16'h0001);
    repeat (5) @(posedge clk);
    por_detect <= 1'b0;
    wait_release(n);
    check(16'(n), 16'd17);
    check(16'(power_loss_flag), 16'h0001);
    @(posedge clk);
    rdchk(8'hE1, 8'h00);
  endtask : t_por

  // Restarts inside the timeout with the CPU idle and idle-run set: no reset
  task automatic t_run();
    wr(8'hE2, 8'h00);
    cpu_idle <= 1'b1;
    k = wd_pulses;
    repeat (4) begin
      wr(8'hE1, 8'h38);
      repeat (150) @(posedge clk);
    end
    check(16'(wd_pulses - k), 16'h0000);
    check(16'(sys_reset), 16'h0000);
    wr(8'hE1, 8'h38);
    wait_timeout(n);
    check(16'(n), 16'(`WDP_OSC_DIV * 2 * (1 << CW) - 1));
    check(16'(sys_reset), 16'h0001);
    wait_release(n);
    check(16'(n), 16'd4);
    check(16'(cpu_start), 16'h0001);
    check(restart_vector, 16'h0000);
    check(16'(power_loss_flag), 16'h0000);
    @(posedge clk);
    cpu_idle <= 1'b0;
    rdchk(8'hE1, 8'h00);
  endtask : t_run

  // Paused by idle without idle-run, stopped by run-enable zero
  task automatic t_wdt();
    k = wd_pulses;
    cpu_idle <= 1'b1;
    wr(8'hE1, 8'h31);
    repeat (300) @(posedge clk);
    check(16'(wd_pulses - k), 16'h0000);
    cpu_idle <= 1'b0;
    wait_timeout(n);
    check(16'(n), 16'(`WDP_OSC_DIV * 4 * (1 << CW)));
    wait_release(n);
    check(16'(n), 16'd4);
    k = wd_pulses;
    @(posedge clk);
    wr(8'hE1, 8'h30);
    repeat (100) @(posedge clk);
    wr(8'hE1, 8'h00);
    repeat (300) @(posedge clk);
    check(16'(wd_pulses - k), 16'h0000);
  endtask : t_wdt

  task automatic summarize();
    $display("Comparisons %0d, mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : summarize

  initial begin
    rst_n = 1'b0;
    por_detect = 1'b0;
    cpu_idle = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    wait_release(n);
    check(16'(n), 16'd17);
    check(16'(cpu_start), 16'h0001);
    @(posedge clk);
    t_regs();
    t_flag();
    t_por();
    t_run();
    t_wdt();
    summarize();
  end

  // Tests need about 2000 cycles
  initial begin
    #100us;
    err_count++;
    summarize();
  end
endmodule : tb_top
